// File: rtl/spi_nvram_pkg.sv
// Opcodes, status field layout, reset values and controller states
// Shared by the SPI front end and the opcode/status controller
package spi_nvram_pkg;
    localparam logic [7:0] OP_STATUS_READ       = 8'h05;
    localparam logic [7:0] OP_STATUS_READ_QUICK = 8'h09;
    localparam logic [7:0] OP_STATUS_WRITE      = 8'h01;
    localparam logic [7:0] OP_LATCH_SET         = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR       = 8'h04;
    localparam logic [7:0] OP_ARRAY_READ        = 8'h03;
    localparam logic [7:0] OP_ARRAY_READ_QUICK  = 8'h0B;
    localparam logic [7:0] OP_ARRAY_WRITE       = 8'h02;
    localparam logic [7:0] OP_STORE             = 8'h3C;
    localparam logic [7:0] OP_RECALL            = 8'h60;
    localparam logic [7:0] OP_AUTOSAVE_ON       = 8'h59;
    localparam logic [7:0] OP_AUTOSAVE_OFF      = 8'h19;
    localparam logic [7:0] OP_SLEEP             = 8'hB9;
    localparam logic [7:0] OP_SN_WRITE          = 8'hC2;
    localparam logic [7:0] OP_SN_READ           = 8'hC3;
    localparam logic [7:0] OP_SN_READ_QUICK     = 8'hC9;
    localparam logic [7:0] OP_ID_READ           = 8'h9F;
    localparam logic [7:0] OP_ID_READ_QUICK     = 8'h99;
    localparam logic [7:0] OP_RESERVED          = 8'h1E;

    localparam int BIT_PIN_PROTECT = 7;
    localparam int BIT_SN_LOCK     = 6;
    localparam int BIT_LEVEL_HI    = 3;
    localparam int BIT_LEVEL_LO    = 2;
    localparam int BIT_WEL         = 1;
    localparam int BIT_BUSY        = 0;

    // Bits a status write may change
    localparam logic [7:0] STATUS_WRITE_MASK = 8'hCC;
    localparam logic [7:0] STATUS_RESET      = 8'h00;
    localparam logic [2:0] BIT_LAST          = 3'h7;
    localparam logic [3:0] SYNC_RESET        = 4'hF;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_OPCODE  = 3'b001,
        ST_DUMMY   = 3'b011,
        ST_SEND    = 3'b010,
        ST_WDATA   = 3'b110,
        ST_PASS    = 3'b111,
        ST_DISCARD = 3'b101
    } ctrl_state_t;

    function automatic logic isWriteClass(input logic [7:0] op);
        return op == OP_STATUS_WRITE || op == OP_ARRAY_WRITE || op == OP_SN_WRITE ||
               op == OP_STORE || op == OP_RECALL || op == OP_AUTOSAVE_ON || op == OP_AUTOSAVE_OFF;
    endfunction : isWriteClass

    function automatic logic isKnown(input logic [7:0] op);
        return isWriteClass(op) || op == OP_STATUS_READ || op == OP_STATUS_READ_QUICK ||
               op == OP_LATCH_SET || op == OP_LATCH_CLEAR || op == OP_ARRAY_READ ||
               op == OP_ARRAY_READ_QUICK || op == OP_SLEEP || op == OP_SN_READ ||
               op == OP_SN_READ_QUICK || op == OP_ID_READ || op == OP_ID_READ_QUICK;
    endfunction : isKnown
endpackage : spi_nvram_pkg

// File: rtl/spi_link_sync.sv
// Pin synchroniser and edge finder for the SPI pins
// Assumes SCK runs well below a quarter of clk
module spi_link_sync (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic csN,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic wpN,
    output logic      csFall,
    output logic      csRise,
    output logic      sckRise,
    output logic      sckFall,
    output logic      sckLevel,
    output logic      siBit,
    output logic      wpLow
);
    typedef struct packed {
        logic [3:0] meta;
        logic [3:0] sync;
        logic [1:0] prev;
        logic       csFall;
        logic       csRise;
        logic       sckRise;
        logic       sckFall;
        logic       sckLevel;
        logic       siBit;
        logic       wpLow;
    } sync_t;

    sync_t q;
    sync_t d;

    always_comb begin
        d = q;
        // First stage feeds only the second stage
        d.meta     = {wpN, si, sck, csN};
        d.sync     = q.meta;
        d.prev     = q.sync[1:0];
        d.csFall   = q.prev[0] & ~q.sync[0];
        d.csRise   = ~q.prev[0] & q.sync[0];
        d.sckRise  = ~q.prev[1] & q.sync[1];
        d.sckFall  = q.prev[1] & ~q.sync[1];
        d.sckLevel = q.sync[1];
        d.siBit    = q.sync[2];
        d.wpLow    = ~q.sync[3];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '{meta: spi_nvram_pkg::SYNC_RESET, sync: spi_nvram_pkg::SYNC_RESET,
                   prev: 2'h1, default: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign csFall   = q.csFall;
    assign csRise   = q.csRise;
    assign sckRise  = q.sckRise;
    assign sckFall  = q.sckFall;
    assign sckLevel = q.sckLevel;
    assign siBit    = q.siBit;
    assign wpLow    = q.wpLow;
endmodule : spi_link_sync

// File: rtl/spi_nvram_opcode_status_ctrl.sv
// Opcode decoder and status/protection register of a serial nvSRAM
// Assumes busy, storeDone and recallDone come from logic on clk
// Behaviour
// R1: First eight bits form the transaction opcode
// R2: MSB first; transactions start at CS fall
// R3: Decode status read, quick read, write
// R4: Decode write latch set and clear
// R5: Decode array read, quick read, write
// R6: Decode store, recall, autosave on/off
// R7: Decode serial number write and reads
// R8: Decode sleep and identity reads
// R9: Master picks normal or quick by rate
// R10: Quick status read skips one dummy byte
// R11: Status bit layout as specified
// R12: Bits five and four read zero
// R13: Busy bit follows store/recall activity
// R14: Write latch clear after power-up
// R15: Status write changes bits 7,6,3,2 only
// R16: Status write is opcode plus data byte
// R17: Serial lock set once, blocks serial writes
// R18: Write-class commands need write latch set
// R19: Rejected write ignored until next frame
// R20: Latch set command sets write latch
// R21: Completed write commands clear write latch
// R22: Status kept nonvolatile only on store
// R23: Unknown opcode discards frame, output off
// R24: Mode from SCK level at select
// R25: Latch clear acts at CS rise
// R26: Protect pin low blocks status write; the code blocks it only while status bit 7 is set
// R27: Reserved opcode behaves as unknown
module spi_nvram_opcode_status_ctrl (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       csN,
    input  wire logic       sck,
    input  wire logic       si,
    input  wire logic       wpN,
    input  wire logic       busy,
    input  wire logic       storeDone,
    input  wire logic       recallDone,
    output logic            so,
    output logic            soOe,
    output logic [7:0]      statusBits,
    output logic            cmdStrobe,
    output logic [7:0]      cmdOpcode,
    output logic            cmdAccepted,
    output logic            modeThree,
    output logic            frameEnd
);
    typedef struct packed {
        spi_nvram_pkg::ctrl_state_t state;
        logic [2:0] bitCnt;
        logic [7:0] shiftIn;
        logic [7:0] shiftOut;
        logic [7:0] opcode;
        logic [7:0] status;
        logic [7:0] nvBits;
        logic [7:0] statusOut;
        logic       mode3;
        logic       pendingClear;
        logic       so;
        logic       soOe;
        logic       cmdStrobe;
        logic       cmdAccepted;
        logic       frameEnd;
    } ctrl_t;

    ctrl_t q;
    ctrl_t d;

    logic       csFall;
    logic       csRise;
    logic       sckRise;
    logic       sckFall;
    logic       sckLevel;
    logic       siBit;
    logic       wpLow;
    logic [7:0] byteIn;
    logic [7:0] statusNow;
    logic       wel;
    logic       accept;

    spi_link_sync u_sync (
        .clk      (clk),
        .resetn   (resetn),
        .csN      (csN),
        .sck      (sck),
        .si       (si),
        .wpN      (wpN),
        .csFall   (csFall),
        .csRise   (csRise),
        .sckRise  (sckRise),
        .sckFall  (sckFall),
        .sckLevel (sckLevel),
        .siBit    (siBit),
        .wpLow    (wpLow)
    );

    assign byteIn = {q.shiftIn[6:0], siBit}; // R2
    assign wel    = q.status[spi_nvram_pkg::BIT_WEL];
    // Reserved bits are never stored, busy is live
    assign statusNow = {q.status[7:6], 2'h0, q.status[3:1], busy}; // R11 R12 R13

    // Write-class needs the latch; pin check is taken once at decode, so
    // a later pin change cannot spoil a status write already under way
    assign accept = spi_nvram_pkg::isKnown(byteIn) // R23 R27
        && !(spi_nvram_pkg::isWriteClass(byteIn) && !wel) // R18
        && !(byteIn == spi_nvram_pkg::OP_SN_WRITE && q.status[spi_nvram_pkg::BIT_SN_LOCK]) // R17
        && !(byteIn == spi_nvram_pkg::OP_STATUS_WRITE
             && q.status[spi_nvram_pkg::BIT_PIN_PROTECT] && wpLow); // R26

    always_comb begin
        d = q;
        d.cmdStrobe = 1'b0;
        d.frameEnd  = 1'b0;
        d.statusOut = statusNow;
        if (storeDone) begin
            d.nvBits = q.status & spi_nvram_pkg::STATUS_WRITE_MASK; // R22
        end
        if (recallDone) begin
            d.status = (q.status & ~spi_nvram_pkg::STATUS_WRITE_MASK) | q.nvBits; // R22
            // An older shadow copy must not unlock the serial number
            d.status[spi_nvram_pkg::BIT_SN_LOCK] =
                q.status[spi_nvram_pkg::BIT_SN_LOCK] | q.nvBits[spi_nvram_pkg::BIT_SN_LOCK]; // R17
        end
        if (csRise) begin
            d.state    = spi_nvram_pkg::ST_IDLE; // R19
            d.soOe     = 1'b0;
            d.frameEnd = 1'b1;
            if (q.pendingClear) begin
                d.status[spi_nvram_pkg::BIT_WEL] = 1'b0; // R21 R25
            end
            d.pendingClear = 1'b0;
        end else if (csFall) begin
            d.state        = spi_nvram_pkg::ST_OPCODE; // R2
            d.bitCnt       = 3'h0;
            d.mode3        = sckLevel; // R24
            d.soOe         = 1'b0;
            d.pendingClear = 1'b0;
        end else if (sckRise && q.state != spi_nvram_pkg::ST_IDLE) begin
            // Both modes sample on the rising edge
            d.shiftIn = byteIn; // R24
            d.bitCnt  = 3'(q.bitCnt + 3'h1);
            unique case (q.state)
                spi_nvram_pkg::ST_OPCODE: begin
                    if (q.bitCnt == spi_nvram_pkg::BIT_LAST) begin
                        d.opcode      = byteIn; // R1
                        d.cmdStrobe   = 1'b1;
                        d.cmdAccepted = accept;
                        d.state       = spi_nvram_pkg::ST_PASS;
                        if (!accept) begin
                            d.state = spi_nvram_pkg::ST_DISCARD; // R19 R23 R27
                        end else begin
                            unique case (byteIn)
                                spi_nvram_pkg::OP_STATUS_READ: begin
                                    d.state    = spi_nvram_pkg::ST_SEND; // R3
                                    d.shiftOut = statusNow;
                                end
                                spi_nvram_pkg::OP_STATUS_READ_QUICK: begin
                                    d.state = spi_nvram_pkg::ST_DUMMY; // R3 R9 R10
                                end
                                spi_nvram_pkg::OP_STATUS_WRITE: begin
                                    d.state = spi_nvram_pkg::ST_WDATA; // R3 R16
                                end
                                spi_nvram_pkg::OP_LATCH_SET: begin
                                    d.status[spi_nvram_pkg::BIT_WEL] = 1'b1; // R4 R20
                                end
                                spi_nvram_pkg::OP_LATCH_CLEAR: begin
                                    d.pendingClear = 1'b1; // R4 R25
                                end
                                default: begin
                                    // Array, nonvolatile, serial, sleep, identity
                                    d.pendingClear = spi_nvram_pkg::isWriteClass(byteIn); // R5 R6 R7 R8 R21
                                end
                            endcase
                        end
                    end
                end
                spi_nvram_pkg::ST_DUMMY: begin
                    if (q.bitCnt == spi_nvram_pkg::BIT_LAST) begin
                        d.state    = spi_nvram_pkg::ST_SEND; // R10
                        d.shiftOut = statusNow;
                    end
                end
                spi_nvram_pkg::ST_SEND: begin
                    // Status repeats while the master keeps clocking
                    if (q.bitCnt == spi_nvram_pkg::BIT_LAST) begin
                        d.shiftOut = statusNow;
                    end
                end
                spi_nvram_pkg::ST_WDATA: begin
                    if (q.bitCnt == spi_nvram_pkg::BIT_LAST) begin
                        d.status = (q.status & ~spi_nvram_pkg::STATUS_WRITE_MASK)
                                 | (byteIn & spi_nvram_pkg::STATUS_WRITE_MASK); // R15 R16
                        // Lock can only ever go from zero to one
                        d.status[spi_nvram_pkg::BIT_SN_LOCK] =
                            q.status[spi_nvram_pkg::BIT_SN_LOCK] | byteIn[spi_nvram_pkg::BIT_SN_LOCK]; // R17
                        d.pendingClear = 1'b1; // R21
                        d.state        = spi_nvram_pkg::ST_PASS;
                    end
                end
                spi_nvram_pkg::ST_PASS, spi_nvram_pkg::ST_DISCARD: begin
                end
                default: begin
                    d.state = spi_nvram_pkg::ST_DISCARD;
                end
            endcase
        end else if (sckFall && q.state == spi_nvram_pkg::ST_SEND) begin
            d.so       = q.shiftOut[7]; // R2
            d.shiftOut = {q.shiftOut[6:0], 1'b0};
            d.soOe     = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // Latch and volatile status come up clear
            q <= '{state: spi_nvram_pkg::ST_IDLE, status: spi_nvram_pkg::STATUS_RESET,
                   nvBits: spi_nvram_pkg::STATUS_RESET, default: '0}; // R14
        end else begin
            q <= d;
        end
    end

    assign so          = q.so;
    assign soOe        = q.soOe;
    assign statusBits  = q.statusOut;
    assign cmdStrobe   = q.cmdStrobe;
    assign cmdOpcode   = q.opcode;
    assign cmdAccepted = q.cmdAccepted;
    assign modeThree   = q.mode3;
    assign frameEnd    = q.frameEnd;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    chk_wel_set_cmd: assert property ( // R20
        cmdStrobe && cmdAccepted && cmdOpcode == spi_nvram_pkg::OP_LATCH_SET |=> ##1 statusBits[1])
        else $error("latch set did not reach status");
    chk_reject_no_wel: assert property ( // R18
        cmdStrobe && spi_nvram_pkg::isWriteClass(cmdOpcode) && !$past(wel) |-> !cmdAccepted)
        else $error("write command accepted without latch");
    chk_unknown_discard: assert property ( // R23
        cmdStrobe && !spi_nvram_pkg::isKnown(cmdOpcode) |-> !cmdAccepted && q.state == spi_nvram_pkg::ST_DISCARD)
        else $error("unknown opcode not discarded");
    chk_discard_output_off: assert property ( // R23
        q.state == spi_nvram_pkg::ST_DISCARD |-> !soOe)
        else $error("output driven while discarding");
    chk_reserved_clean: assert property ( // R27
        cmdStrobe && cmdOpcode == spi_nvram_pkg::OP_RESERVED && !storeDone && !recallDone |=> $stable(q.status))
        else $error("reserved opcode touched status");
    chk_bits_zero: assert property ( // R12
        statusBits[5:4] == 2'h0)
        else $error("reserved status bits not zero");
    chk_busy_follow: assert property ( // R13
        statusBits[0] == $past(busy))
        else $error("busy bit does not follow activity");
    chk_lock_sticky: assert property ( // R17
        $past(q.status[6]) |-> q.status[6])
        else $error("serial lock cleared");
    chk_wel_clear_end: assert property ( // R21
        frameEnd && $past(q.pendingClear) |-> !q.status[1] ##2 !statusBits[1])
        else $error("latch not cleared at frame end");

    cov_quick_status: cover property (
        cmdStrobe && cmdAccepted && cmdOpcode == spi_nvram_pkg::OP_STATUS_READ_QUICK);
    cov_status_write: cover property (
        q.state == spi_nvram_pkg::ST_WDATA ##1 q.state == spi_nvram_pkg::ST_PASS);
    cov_rejected_write: cover property (
        cmdStrobe && !cmdAccepted && spi_nvram_pkg::isWriteClass(cmdOpcode));
endmodule : spi_nvram_opcode_status_ctrl

// File: bench/spi_master_model.sv
// Behavioural SPI master that frames one command per chip-select cycle
// Assumes the bench clock drives it; pins change only at clk falling edges
module spi_master_model (
    input  wire logic clk,
    input  wire logic so,
    input  wire logic soOe,
    output logic      csN,
    output logic      sck,
    output logic      si
);
    timeunit 1ns;
    timeprecision 1ps;

    // Half of the 80 ns link period, well below the 40 MHz normal-read limit
    localparam int HALF = 4;

    initial begin
        csN = 1'b1;
        sck = 1'b0;
        si  = 1'b0;
    end

    // Shifts nBits of tx out MSB first and samples so late in each high phase,
    // since the device answers a few clk after the SCK fall
    task automatic frame(input logic m3, input int nBits, input logic [31:0] tx,
                         output logic [31:0] rx, output logic oeSeen);
        rx     = '0;
        oeSeen = 1'b0;
        @(negedge clk);
        sck = m3;
        repeat (HALF) @(negedge clk);
        csN = 1'b0;
        repeat (HALF) @(negedge clk);
        for (int i = nBits - 1; i >= 0; i--) begin
            sck = 1'b0;
            si  = tx[i];
            repeat (HALF) @(negedge clk);
            sck = 1'b1;
            repeat (HALF) @(negedge clk);
            rx     = {rx[30:0], so};
            oeSeen = oeSeen | soOe;
        end
        sck = m3;
        repeat (HALF) @(negedge clk);
        csN = 1'b1;
        // A released line must not keep showing the last bit
        si  = ~si;
        repeat (2 * HALF) @(negedge clk);
    endtask : frame
endmodule : spi_master_model

// File: bench/spi_nvram_opcode_status_ctrl_tb_top.sv
// Self-checking bench for the opcode decoder and status register
// Assumes the master model drives the SPI pins; other inputs change at clk falls
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin error_cnt++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
module spi_nvram_opcode_status_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, resetn, csN, sck, si, wpN, busy, storeDone, recallDone;
    logic        so, soOe, cmdStrobe, cmdAccepted, modeThree, frameEnd, oe;
    logic [7:0]  statusBits, cmdOpcode;
    logic [31:0] rx;
    int          error_cnt, n_tests, strobes, ends, cycles;

    spi_nvram_opcode_status_ctrl DUT (.clk(clk), .resetn(resetn), .csN(csN), .sck(sck), .si(si),
        .wpN(wpN), .busy(busy), .storeDone(storeDone), .recallDone(recallDone), .so(so), .soOe(soOe),
        .statusBits(statusBits), .cmdStrobe(cmdStrobe), .cmdOpcode(cmdOpcode),
        .cmdAccepted(cmdAccepted), .modeThree(modeThree), .frameEnd(frameEnd));
    spi_master_model master (.clk(clk), .so(so), .soOe(soOe), .csN(csN), .sck(sck), .si(si));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Ceiling is about five and a half times the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cmdStrobe === 1'b1) strobes++;
        if (frameEnd === 1'b1) ends++;
        if (cycles == 30000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    task automatic send(input logic m3, input int nb, input logic [31:0] tx, input logic expAcc);
        int s0;
        int e0;
        s0 = strobes;
        e0 = ends;
        master.frame(m3, nb, tx, rx, oe);
        `CHK("strobe count", 1, strobes - s0)
        `CHK("frame ends", 1, ends - e0)
        `CHK("opcode", tx[nb-1 -: 8], cmdOpcode)
        `CHK("accepted", expAcc, cmdAccepted)
        `CHK("mode", m3, modeThree)
    endtask : send

    task automatic pulse(ref logic p);
        p = 1'b1;
        @(negedge clk);
        p = 1'b0;
        repeat (3) @(negedge clk);
    endtask : pulse

    task automatic t_reset_vals();
        `CHK("reset status", 8'h00, statusBits)
        `CHK("reset oe", 1'b0, soOe)
    endtask : t_reset_vals

    // Latch is clear here, so every write-class code must be refused
    task automatic t_opcode_table();
        logic [7:0] ops [19] = '{8'h05, 8'h09, 8'h04, 8'h03, 8'h0B, 8'hB9, 8'hC3, 8'hC9, 8'h9F, 8'h99,
                                 8'h01, 8'h02, 8'h3C, 8'h60, 8'h59, 8'h19, 8'hC2, 8'h1E, 8'hFF};
        for (int i = 0; i < 19; i++) begin
            send(1'b0, 16, {16'h0, ops[i], 8'hFF}, i < 10);
            `CHK("output enable", i == 0, oe)
            if (i == 0) begin
                `CHK("read byte", 8'h00, rx[7:0])
            end
            `CHK("side effects", 8'h00, statusBits)
        end
    endtask : t_opcode_table

    task automatic t_write_class();
        logic [7:0] ops [6] = '{8'h02, 8'h3C, 8'h60, 8'h59, 8'h19, 8'hC2};
        for (int i = 0; i < 6; i++) begin
            send(1'b0, 8, 32'h06, 1'b1);
            `CHK("latch set", 1'b1, statusBits[1])
            send(1'b0, 8, {24'h0, ops[i]}, 1'b1);
            `CHK("latch after write", 1'b0, statusBits[1])
        end
    endtask : t_write_class

    task automatic t_status_write();
        send(1'b0, 8, 32'h06, 1'b1);
        send(1'b0, 16, 32'h01FF, 1'b1);
        `CHK("status write", 8'hCC, statusBits)
    endtask : t_status_write

    task automatic t_reads_busy();
        busy = 1'b1;
        send(1'b1, 24, 32'h090000, 1'b1);
        `CHK("quick read", 8'hCD, rx[7:0])
        `CHK("quick oe", 1'b1, oe)
        send(1'b1, 16, 32'h0500, 1'b1);
        `CHK("normal read", 8'hCD, rx[7:0])
        busy = 1'b0;
        repeat (3) @(negedge clk);
        `CHK("busy low", 8'hCC, statusBits)
    endtask : t_reads_busy

    task automatic t_lock_protect();
        send(1'b0, 8, 32'h06, 1'b1);
        send(1'b0, 8, 32'hC2, 1'b0);
        `CHK("latch kept", 1'b1, statusBits[1])
        wpN = 1'b0;
        send(1'b0, 16, 32'h0100, 1'b0);
        `CHK("protected", 8'hCE, statusBits)
        wpN = 1'b1;
        send(1'b0, 16, 32'h0100, 1'b1);
        `CHK("lock kept", 8'h40, statusBits)
    endtask : t_lock_protect

    task automatic t_store_recall();
        pulse(storeDone);
        send(1'b0, 8, 32'h06, 1'b1);
        send(1'b0, 16, 32'h018C, 1'b1);
        `CHK("volatile", 8'hCC, statusBits)
        pulse(recallDone);
        `CHK("recalled", 8'h40, statusBits)
    endtask : t_store_recall

    task automatic t_latch_clear();
        send(1'b0, 8, 32'h06, 1'b1);
        send(1'b1, 8, 32'h04, 1'b1);
        `CHK("latch cleared", 8'h40, statusBits)
    endtask : t_latch_clear

    initial begin
        resetn     = 1'b0;
        wpN        = 1'b1;
        busy       = 1'b0;
        storeDone  = 1'b0;
        recallDone = 1'b0;
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        repeat (6) @(negedge clk);
        t_reset_vals();
        t_opcode_table();
        t_write_class();
        t_status_write();
        t_reads_busy();
        t_lock_protect();
        t_store_recall();
        t_latch_clear();
        test_done();
    end
endmodule : spi_nvram_opcode_status_ctrl_tb_top
